// file: hdl/osa_output_signal_allocator.sv
// Output signal allocator: routes status signals onto three sequence
// outputs through allocation digits and polarity bits.
// Assumes status and mode come from logic on the same clock, and that
// restart pulses once when the drive is powered up again.
`timescale 1ns/1ps
`default_nettype none

module osa_output_signal_allocator
	import osa_pkg::*;
#(
	parameter int FLASH_CYCLES = OSA_FLASH_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic restart,
	input wire osa_status_t status,
	input wire osa_mode_t control_mode,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [2:0] seq_out,
	output logic display_flash
);

	// ==========================================================
	// Bus decode
	logic wb_req;
	logic wb_wr;
	logic [15:0] edit_a;
	logic [15:0] edit_b;
	logic [15:0] edit_c;
	logic [2:0] edit_pol;
	logic [15:0] kept_a;
	logic [15:0] kept_b;
	logic [15:0] kept_c;
	logic [2:0] kept_pol;
	logic [15:0] act_a;
	logic [15:0] act_b;
	logic [15:0] act_c;
	logic [2:0] act_pol;
	logic store_req;
	logic [31:0] flash_cnt;
	logic [4*OSA_DIGITS-1:0] digits;
	logic [OSA_DIGITS-1:0] sig_valid;
	logic [OSA_OUTPUTS-1:0] routed;
	logic [31:0] next_rdata;

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_req && wb_we_i;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] din, input logic [3:0] sel);
		logic [15:0] res;
		res = old;
		if (sel[0]) begin
			res[7:0] = din[7:0];
		end
		if (sel[1]) begin
			res[15:8] = din[15:8];
		end
		return res;
	endfunction

	// ==========================================================
	// Panel edit registers
	always_ff @(posedge clk) begin
		if (srst) begin
			edit_a <= OSA_RESET_ALLOC_A;
			edit_b <= OSA_RESET_ALLOC_B;
			edit_c <= OSA_RESET_ALLOC_C;
			edit_pol <= OSA_RESET_POLARITY;
		end else if (wb_wr) begin
			unique case (wb_adr_i)
				OSA_ADDR_ALLOC_A: begin
					edit_a <= merge16(edit_a, wb_dat_i, wb_sel_i);
				end
				OSA_ADDR_ALLOC_B: begin
					edit_b <= merge16(edit_b, wb_dat_i, wb_sel_i);
				end
				OSA_ADDR_ALLOC_C: begin
					edit_c <= merge16(edit_c, wb_dat_i, wb_sel_i);
				end
				OSA_ADDR_POLARITY: begin
					if (wb_sel_i[0]) begin
						edit_pol <= wb_dat_i[2:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	assign store_req = wb_wr && (wb_adr_i == OSA_ADDR_CONTROL) &&
		wb_sel_i[0] && wb_dat_i[OSA_CTRL_STORE_BIT];

	// ==========================================================
	// Retained copy, written only by the set key
	always_ff @(posedge clk) begin
		if (srst) begin
			kept_a <= OSA_RESET_ALLOC_A;
			kept_b <= OSA_RESET_ALLOC_B;
			kept_c <= OSA_RESET_ALLOC_C;
			kept_pol <= OSA_RESET_POLARITY;
		end else if (store_req) begin
			kept_a <= edit_a;
			kept_b <= edit_b;
			kept_c <= edit_c;
			kept_pol <= edit_pol;
		end
	end

	// ==========================================================
	// Display flash after a store
	always_ff @(posedge clk) begin
		if (srst) begin
			flash_cnt <= '0;
			display_flash <= 1'b0;
		end else if (store_req) begin
			flash_cnt <= 32'(FLASH_CYCLES - 1);
			display_flash <= 1'b1;
		end else if (flash_cnt != '0) begin
			flash_cnt <= flash_cnt - 32'h00000001;
		end else begin
			display_flash <= 1'b0;
		end
	end

	// ==========================================================
	// Active settings, loaded only at power-up
	always_ff @(posedge clk) begin
		if (srst) begin
			act_a <= OSA_RESET_ALLOC_A;
			act_b <= OSA_RESET_ALLOC_B;
			act_c <= OSA_RESET_ALLOC_C;
			act_pol <= OSA_RESET_POLARITY;
		end else if (restart) begin
			act_a <= kept_a;
			act_b <= kept_b;
			act_c <= kept_c;
			act_pol <= kept_pol;
		end
	end

	// ==========================================================
	// Signal validity per digit slot
	assign digits = {act_c, act_b, act_a};

	always_comb begin
		sig_valid = {1'b0, status.pulse_multiplier_switch_ack, 1'b0,
			status.near_position, status.warning,
			status.brake_interlock_output, status.speed_limit_detect,
			status.torque_limit_detect, status.servo_ready,
			status.rotation_detect_output, status.speed_coincidence,
			status.positioning_complete_output};
		if (control_mode != OSA_MODE_POSITION) begin
			sig_valid[0] = 1'b0;
			sig_valid[8] = 1'b0;
			sig_valid[10] = 1'b0;
		end
		if (control_mode != OSA_MODE_SPEED) begin
			sig_valid[1] = 1'b0;
		end
	end

	// ==========================================================
	// Routing per output circuit
	genvar gj;
	generate
		for (gj = 0; gj < OSA_OUTPUTS; gj++) begin : g_route
			always_comb begin
				routed[gj] = 1'b0;
				for (int k = 0; k < OSA_DIGITS; k++) begin
					if (digits[4*k +: 4] == 4'(gj + 1)) begin
						routed[gj] = routed[gj] | sig_valid[k];
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Output circuits with polarity
	always_ff @(posedge clk) begin
		if (srst) begin
			seq_out <= 3'h0;
		end else begin
			seq_out[0] <= routed[0] ^ act_pol[0];
			seq_out[1] <= routed[1] ^ act_pol[1];
			seq_out[2] <= routed[2] ^ act_pol[2];
		end
	end

	// ==========================================================
	// Bus read and acknowledge
	always_comb begin
		next_rdata = 32'h00000000;
		unique case (wb_adr_i)
			OSA_ADDR_ALLOC_A: next_rdata[15:0] = edit_a;
			OSA_ADDR_ALLOC_B: next_rdata[15:0] = edit_b;
			OSA_ADDR_ALLOC_C: next_rdata[15:0] = edit_c;
			OSA_ADDR_POLARITY: next_rdata[2:0] = edit_pol;
			OSA_ADDR_CONTROL: next_rdata[OSA_CTRL_BUSY_BIT] = display_flash;
			OSA_ADDR_MONITOR: next_rdata[2:0] = seq_out;
			OSA_ADDR_ACTIVE_POL: next_rdata[2:0] = act_pol;
			default: next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? next_rdata : 32'h00000000;
		end
	end

endmodule

`default_nettype wire

// file: hdl/osa_pkg.sv
// Constants and types for the output signal allocator.
// Assumes one 125 MHz clock and a synchronous active-high reset.
// Contract
// - Polarity bit one inverts the second sequence output.
// - Allocation digit zero routes the signal to no output.
// - Allocation digit two routes the signal to the second output.
// - Set key stores edited value in retained memory and flashes display.
// - Changed settings only take effect at the next power-up.
// - Present state of every sequence output is readable as monitor.
// - Several signals on one output are combined by OR.
// - Signals not detected in the current control mode are invalid.
package osa_pkg;

	// ==========================================================
	// Register map (byte addresses, 32-bit words)
	localparam logic [7:0] OSA_ADDR_ALLOC_A = 8'h00;
	localparam logic [7:0] OSA_ADDR_ALLOC_B = 8'h04;
	localparam logic [7:0] OSA_ADDR_ALLOC_C = 8'h08;
	localparam logic [7:0] OSA_ADDR_POLARITY = 8'h0C;
	localparam logic [7:0] OSA_ADDR_CONTROL = 8'h10;
	localparam logic [7:0] OSA_ADDR_MONITOR = 8'h14;
	localparam logic [7:0] OSA_ADDR_ACTIVE_POL = 8'h18;

	// ==========================================================
	// Field positions and widths
	localparam int OSA_DIGITS = 12;
	localparam int OSA_OUTPUTS = 3;
	localparam int OSA_CTRL_STORE_BIT = 0;
	localparam int OSA_CTRL_BUSY_BIT = 1;

	// ==========================================================
	// Values after reset (factory settings)
	localparam logic [15:0] OSA_RESET_ALLOC_A = 16'h3211;
	localparam logic [15:0] OSA_RESET_ALLOC_B = 16'h0000;
	localparam logic [15:0] OSA_RESET_ALLOC_C = 16'h0000;
	localparam logic [2:0] OSA_RESET_POLARITY = 3'h0;

	// ==========================================================
	// Timing: display flash after a store
	localparam int OSA_CLK_MHZ = 125;
	localparam int OSA_FLASH_TIME_MS = 500;
	localparam int OSA_FLASH_CYCLES = OSA_FLASH_TIME_MS * 1000 * OSA_CLK_MHZ;

	// ==========================================================
	// Internal status signals of the drive
	typedef struct packed {
		logic pulse_multiplier_switch_ack;
		logic near_position;
		logic warning;
		logic brake_interlock_output;
		logic speed_limit_detect;
		logic torque_limit_detect;
		logic servo_ready;
		logic rotation_detect_output;
		logic speed_coincidence;
		logic positioning_complete_output;
	} osa_status_t;

	typedef enum logic [1:0] {
		OSA_MODE_SPEED,
		OSA_MODE_POSITION,
		OSA_MODE_TORQUE
	} osa_mode_t;

endpackage

// file: verification/osa_checker_asserts.sv
// Checker on the allocator ports.
// Assumes FLASH_CYCLES of 8.
`timescale 1ns/1ps
`default_nettype none
module osa_checker
	import osa_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic restart,
	input wire osa_status_t status,
	input wire osa_mode_t control_mode,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [2:0] seq_out,
	input wire logic display_flash
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 0)
		else $error("read data outside ack");
	mon_read_a: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i == OSA_ADDR_MONITOR
		|-> wb_dat_o[2:0] == $past(seq_out)) else $error("monitor wrong");
	miss_read_a: assert property (wb_ack_o && wb_adr_i > 8'h18
		|-> wb_dat_o == 0) else $error("unmapped read not zero");
	flash_go_a: assert property (
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
		wb_adr_i == OSA_ADDR_CONTROL && wb_dat_i[0] |=> display_flash)
		else $error("no flash after store");
	flash_len_a: assert property (
		$rose(display_flash) |-> display_flash [*8] ##1 !display_flash)
		else $error("flash length wrong");
	out_hold_a: assert property (
		(!restart && $stable(status) && $stable(control_mode)) [*4]
		|-> $stable(seq_out)) else $error("output moved without cause");
endmodule
bind osa_output_signal_allocator osa_checker i_osa_checker (
	.clk(clk),
	.srst(srst),
	.restart(restart),
	.status(status),
	.control_mode(control_mode),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.seq_out(seq_out),
	.display_flash(display_flash)
);
`default_nettype wire

// file: verification/osa_relay_model.sv
// Relay that follows the three sequence outputs.
// Assumes outputs are levels on the bench clock.
`timescale 1ns/1ps
`default_nettype none
module osa_relay_model (
	input wire logic clk,
	input wire logic [2:0] seq_out,
	output logic [2:0] contact
);
	always_ff @(posedge clk) begin
		contact <= seq_out;
	end
endmodule
`default_nettype wire

// file: verification/output_signal_allocator_bench.sv
// Bench for the allocator; outputs are read through the monitor.
// Assumes FLASH_CYCLES of 8.
`timescale 1ns/1ps
`default_nettype none
module output_signal_allocator_bench
	import osa_pkg::*;
();
	logic clk = 0, srst = 1, restart = 0, wb_cyc_i = 0, wb_stb_i = 0;
	logic wb_we_i = 0, wb_ack_o, display_flash;
	logic [7:0] wb_adr_i = 0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 0, wb_dat_o, r = 32'hB004;
	logic [31:0] q[$];
	logic [31:0] exp_rd;
	logic [2:0] seq_out, contact;
	osa_status_t status = '0;
	osa_mode_t control_mode = OSA_MODE_SPEED;
	int num_errors = 0, comparisons = 0;
	osa_output_signal_allocator #(
		.FLASH_CYCLES(8)
	) i_osa_output_signal_allocator (
		.clk(clk),
		.srst(srst),
		.restart(restart),
		.status(status),
		.control_mode(control_mode),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.seq_out(seq_out),
		.display_flash(display_flash)
	);
	osa_relay_model i_osa_relay_model (
		.clk(clk),
		.seq_out(seq_out),
		.contact(contact)
	);
	// ==========================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic [2:0] route(input logic [47:0] al,
		input logic [2:0] p, input logic [9:0] s, input logic [1:0] m);
		logic [2:0] o;
		logic [3:0] d;
		o = 0;
		for (int i = 0; i < 10; i++) begin
			d = al[4 * (i == 9 ? 10 : i) +: 4];
			if ((i == 0 || i > 7) && m != 2'h1) d = 0;
			if (i == 1 && m != 2'h0) d = 0;
			if (s[i] && d > 0 && d < 4) o[d - 1] = 1;
		end
		return o ^ p;
	endfunction
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(a, 0, 0);
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic run(input logic [47:0] al, input logic [2:0] p);
		logic [1:0] m;
		repeat (16) begin
			r = xs(r);
			m = r[11:10] == 2'h3 ? 2'h0 : r[11:10];
			status <= r[9:0];
			control_mode <= osa_mode_t'(m);
			repeat (3) @(posedge clk);
			rd(OSA_ADDR_MONITOR, {29'h0, route(al, p, r[9:0], m)});
		end
	endtask
	task automatic give_verdict;
		$display("Errors %0d, comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ==========================================
	// Clock, checks, watchdog, sequence
	initial begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (wb_ack_o === 1'b1 && !wb_we_i) begin
			exp_rd = q.pop_front();
			cmp(wb_dat_o, exp_rd);
			if (wb_adr_i == OSA_ADDR_MONITOR) begin
				cmp({29'h0, contact}, exp_rd);
			end
		end
	end
	initial begin
		#40000;
		num_errors++;
		give_verdict;
	end
	initial begin
		repeat (2) @(posedge clk);
		srst <= 0;
		rd(OSA_ADDR_POLARITY, 0);
		run(48'h3211, 3'h0);
		bus(OSA_ADDR_ALLOC_A, 1, 32'h3011);
		bus(OSA_ADDR_ALLOC_B, 1, 32'h4200);
		bus(OSA_ADDR_ALLOC_C, 1, 32'h0113);
		bus(OSA_ADDR_POLARITY, 1, 32'h7);
		bus(OSA_ADDR_CONTROL, 1, 32'h1);
		rd(OSA_ADDR_CONTROL, 32'h1 << OSA_CTRL_BUSY_BIT);
		rd(OSA_ADDR_ALLOC_B, 32'h4200);
		run(48'h3211, 3'h0);
		rd(OSA_ADDR_CONTROL, 0);
		rd(OSA_ADDR_ACTIVE_POL, 0);
		restart <= 1;
		@(posedge clk);
		restart <= 0;
		run(48'h0113_4200_3011, 3'h7);
		rd(OSA_ADDR_ACTIVE_POL, 7);
		rd(8'h1C, 0);
		give_verdict;
	end
endmodule
`default_nettype wire
